/* File: rtl/accumulator_data_move_unit.sv */
// Purpose: Moves data between the 16-bit accumulator and references
// Assumes: Inputs synchronous to I_CLK; memory acks each request once
// Notes:   Byte refs return {next byte, named byte} on the answer bus
//
// Contract
// RQ1: Code 50 loads the accumulator from a BCD constant or a word ref.
// RQ2: Code 51 loads bits 7..0 from a byte ref and zeroes bits 15..8.
// RQ3: Code 52 loads bits 3..0 from the high nibble of a byte ref.
// RQ4: Code 53 loads bits 3..0 from the low nibble of a byte ref.
// RQ5: Code 55 loads the accumulator from a 16-circuit input module.
// RQ6: Code 60 writes all sixteen accumulator bits to a word ref.
// RQ7: Code 60 accepts I/O, relay, shift, data and timer refs.
// RQ8: Code 61 writes accumulator bits 7..0 to a byte ref.
// RQ9: Code 62 writes accumulator bits 3..0 into a ref's high nibble.
// RQ10: Code 63 writes accumulator bits 3..0 into a ref's low nibble.
// RQ11: Without power flow neither accumulator nor target changes.
// RQ12: A word ref is the named byte (low digits) and the next byte.
// RQ13: Data refs decode at octal 400-577, timer words at 600-677.
// RQ14: Nibble moves leave every bit outside the nibble unchanged.
`timescale 1ns/1ps
`include "acc_move_regs.svh"

module accumulator_data_move_unit (
   // Clock and reset
   input  wire logic                 I_CLK,
   input  wire logic                 I_RSTN,
   // Instruction from the scan
   input  wire logic                 I_EXEC,
   input  wire logic                 I_POWER,
   input  wire acc_move_pkg::instr_t I_INSTR,
   // Reference memory
   output acc_move_pkg::mem_req_t    O_MEM,
   input  wire acc_move_pkg::mem_rsp_t I_MEM,
   // Status
   output logic [15:0]               O_ACC,
   output logic                      O_BUSY,
   output logic                      O_DONE,
   output logic                      O_REFUSED
);

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Word refs stop one byte early so the pair stays in range
   function automatic logic ref_ok(input logic [8:0] a,
                                   input logic       wide);
      logic [8:0] io_hi;
      logic [8:0] io2_hi;
      logic [8:0] rel_hi;
      logic [8:0] shr_hi;
      logic [8:0] dat_hi;
      io_hi  = wide ? `AM_IO_HI_W  : `AM_IO_HI_B;
      io2_hi = wide ? `AM_IO2_HI_W : `AM_IO2_HI_B;
      rel_hi = wide ? `AM_REL_HI_W : `AM_REL_HI_B;
      shr_hi = wide ? `AM_SHR_HI_W : `AM_SHR_HI_B;
      dat_hi = wide ? `AM_DAT_HI_W : `AM_DAT_HI_B;
      ref_ok = (a <= io_hi)
            || (a >= `AM_IO2_LO && a <= io2_hi)
            || (a >= `AM_REL_LO && a <= rel_hi)
            || (a >= `AM_SHR_LO && a <= shr_hi)
            || (a >= `AM_DAT_LO && a <= dat_hi)          // RQ13
            || (wide && is_tc(a));
   endfunction : ref_ok

   function automatic logic is_tc(input logic [8:0] a);
      is_tc = (a >= `AM_TC_LO) && (a <= `AM_TC_HI);      // RQ13
   endfunction : is_tc

   function automatic logic bcd_ok(input logic [15:0] k);
      bcd_ok = (k[3:0] <= `AM_BCD_MAX) && (k[7:4] <= `AM_BCD_MAX)
            && (k[11:8] <= `AM_BCD_MAX)
            && (k[15:12] <= `AM_BCD_MAX);
   endfunction : bcd_ok

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   acc_move_pkg::state_t   state_q;
   logic [7:0]             op_q;
   logic [15:0]            acc_q;
   acc_move_pkg::mem_req_t mem_q;
   logic                   done_q;
   logic                   refused_q;

   // Classification of the offered instruction
   logic       idle;
   logic       start;
   logic [7:0] op;
   logic [8:0] ra;
   logic       is_load_ref;
   logic       is_store;
   logic       legal;

   assign idle  = (state_q == acc_move_pkg::ST_IDLE);
   assign start = idle && I_EXEC && I_POWER;             // RQ11
   assign op    = I_INSTR.opcode;
   assign ra    = I_INSTR.ref_addr;

   // Legality per opcode; constants only make sense for code 50
   always_comb begin
      is_load_ref = 1'b0;
      is_store    = 1'b0;
      legal       = 1'b0;
      case (op)
         `AM_OP_LOAD_WORD: begin
            is_load_ref = !I_INSTR.use_const;
            legal = I_INSTR.use_const ? bcd_ok(I_INSTR.konst)
                                      : ref_ok(ra, 1'b1);  // RQ1
         end
         `AM_OP_LOAD_BYTE, `AM_OP_LOAD_HI_NIB,
         `AM_OP_LOAD_LO_NIB: begin
            is_load_ref = 1'b1;
            legal = ref_ok(ra, 1'b0) && !is_tc(ra);
         end
         `AM_OP_LOAD_INMOD: begin
            is_load_ref = 1'b1;
            legal = (ra <= `AM_INMOD_HI);                  // RQ5
         end
         `AM_OP_STORE_WORD: begin
            is_store = 1'b1;
            legal = ref_ok(ra, 1'b1);                      // RQ7
         end
         `AM_OP_STORE_BYTE, `AM_OP_STORE_HI,
         `AM_OP_STORE_LO: begin
            is_store = 1'b1;
            legal = ref_ok(ra, 1'b0) && !is_tc(ra);
         end
         default: begin
            legal = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Request held until the memory acks it
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         state_q <= acc_move_pkg::ST_IDLE;
         op_q    <= `AM_ZERO_BYTE;
      end else begin
         case (state_q)
            acc_move_pkg::ST_IDLE: begin
               if (start && legal && is_load_ref) begin
                  state_q <= acc_move_pkg::ST_READ;
                  op_q    <= op;
               end else if (start && legal && is_store) begin
                  state_q <= acc_move_pkg::ST_WRITE;
                  op_q    <= op;
               end
            end
            acc_move_pkg::ST_READ, acc_move_pkg::ST_WRITE: begin
               if (I_MEM.ack) begin
                  state_q <= acc_move_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= acc_move_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Memory request
   // ------------------------------------------------------------
   // Store data and lanes are built once, from the idle accumulator
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         mem_q <= '0;
      end else if (idle && start && legal && (is_load_ref || is_store)) begin
         mem_q.req    <= 1'b1;
         mem_q.wr     <= is_store;
         mem_q.tc     <= is_tc(ra);                        // RQ13
         mem_q.addr   <= ra;
         mem_q.data   <= `AM_ACC_RESET;
         mem_q.nib_en <= `AM_NIB_NONE;
         case (op)
            `AM_OP_STORE_WORD: begin
               mem_q.data   <= acc_q;                      // RQ6
               mem_q.nib_en <= `AM_NIB_ALL;
            end
            `AM_OP_STORE_BYTE: begin
               mem_q.data   <= {`AM_ZERO_BYTE, acc_q[7:0]}; // RQ8
               mem_q.nib_en <= `AM_NIB_BYTE;
            end
            `AM_OP_STORE_HI: begin
               mem_q.data   <= {`AM_ZERO_BYTE, acc_q[3:0],
                                `AM_ZERO_NIB};             // RQ9
               mem_q.nib_en <= `AM_NIB_HI;                 // RQ14
            end
            `AM_OP_STORE_LO: begin
               mem_q.data   <= {`AM_ZERO_BYTE, `AM_ZERO_NIB,
                                acc_q[3:0]};               // RQ10
               mem_q.nib_en <= `AM_NIB_LO;                 // RQ14
            end
            default: begin
               mem_q.nib_en <= `AM_NIB_NONE;
            end
         endcase
      end else if (!idle && I_MEM.ack) begin
         mem_q.req <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Accumulator
   // ------------------------------------------------------------
   // Answer low byte is the named byte, high byte the next one
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         acc_q <= `AM_ACC_RESET;
      end else if (start && legal && I_INSTR.use_const
                   && op == `AM_OP_LOAD_WORD) begin
         acc_q <= I_INSTR.konst;                           // RQ1
      end else if (state_q == acc_move_pkg::ST_READ && I_MEM.ack) begin
         case (op_q)
            `AM_OP_LOAD_WORD: begin
               acc_q <= I_MEM.data;                        // RQ12
            end
            `AM_OP_LOAD_BYTE: begin
               acc_q <= {`AM_ZERO_BYTE, I_MEM.data[7:0]};  // RQ2
            end
            `AM_OP_LOAD_HI_NIB: begin
               acc_q[3:0] <= I_MEM.data[7:4];              // RQ3 RQ14
            end
            `AM_OP_LOAD_LO_NIB: begin
               acc_q[3:0] <= I_MEM.data[3:0];              // RQ4 RQ14
            end
            `AM_OP_LOAD_INMOD: begin
               acc_q <= I_MEM.data;                        // RQ5
            end
            default: begin
               acc_q <= acc_q;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Completion and refusal pulses
   // ------------------------------------------------------------
   // Unpowered rungs complete at once and touch nothing
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         done_q    <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         done_q    <= (idle && I_EXEC && (!I_POWER || !legal
                       || (op == `AM_OP_LOAD_WORD
                           && I_INSTR.use_const)))
                   || (!idle && I_MEM.ack);                // RQ11
         refused_q <= idle && I_EXEC && I_POWER && !legal;
      end
   end

   // Outputs
   assign O_MEM     = mem_q;
   assign O_ACC     = acc_q;
   assign O_BUSY    = !idle;
   assign O_DONE    = done_q;
   assign O_REFUSED = refused_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);

   a_no_power_hold: assert property (idle && I_EXEC && !I_POWER
      |=> $stable(O_ACC) && !O_MEM.req && O_DONE) // RQ11
      else $error("unpowered rung changed state");
   a_const_load: assert property (start && legal && I_INSTR.use_const
      && op == `AM_OP_LOAD_WORD |=> O_ACC == $past(I_INSTR.konst)) // RQ1
      else $error("constant not loaded");
   a_word_load: assert property (state_q == acc_move_pkg::ST_READ
      && I_MEM.ack && op_q == `AM_OP_LOAD_WORD
      |=> O_ACC == $past(I_MEM.data) && !O_BUSY) // RQ12
      else $error("word load wrong");
   a_byte_load: assert property (state_q == acc_move_pkg::ST_READ
      && I_MEM.ack && op_q == `AM_OP_LOAD_BYTE
      |=> O_ACC == {`AM_ZERO_BYTE, $past(I_MEM.data[7:0])}) // RQ2
      else $error("byte load wrong");
   a_hi_nib_load: assert property (state_q == acc_move_pkg::ST_READ
      && I_MEM.ack && op_q == `AM_OP_LOAD_HI_NIB
      |=> O_ACC == {$past(O_ACC[15:4]), $past(I_MEM.data[7:4])}) // RQ3
      else $error("high nibble load wrong");
   a_lo_nib_load: assert property (state_q == acc_move_pkg::ST_READ
      && I_MEM.ack && op_q == `AM_OP_LOAD_LO_NIB
      |=> O_ACC == {$past(O_ACC[15:4]), $past(I_MEM.data[3:0])}) // RQ4
      else $error("low nibble load wrong");
   a_inmod_load: assert property (start && legal
      && op == `AM_OP_LOAD_INMOD
      |=> O_MEM.req && !O_MEM.wr && O_MEM.addr <= `AM_INMOD_HI) // RQ5
      else $error("input module read wrong");
   a_store_word: assert property (start && legal
      && op == `AM_OP_STORE_WORD
      |=> O_MEM.wr && O_MEM.nib_en == `AM_NIB_ALL
          && O_MEM.data == $past(O_ACC)) // RQ6
      else $error("word store wrong");
   a_store_byte: assert property (O_MEM.req && O_MEM.wr
      && op_q == `AM_OP_STORE_BYTE |-> O_MEM.nib_en == `AM_NIB_BYTE
      && O_MEM.data[7:0] == O_ACC[7:0]) // RQ8
      else $error("byte store wrong");
   a_store_hi: assert property (O_MEM.req && O_MEM.wr
      && op_q == `AM_OP_STORE_HI |-> O_MEM.nib_en == `AM_NIB_HI
      && O_MEM.data[7:4] == O_ACC[3:0]) // RQ9
      else $error("high nibble store wrong");
   a_store_lo: assert property (O_MEM.req && O_MEM.wr
      && op_q == `AM_OP_STORE_LO |-> O_MEM.nib_en == `AM_NIB_LO
      && O_MEM.data[3:0] == O_ACC[3:0]) // RQ10
      else $error("low nibble store wrong");
   a_tc_decode: assert property (O_MEM.req && O_MEM.tc
      |-> O_MEM.addr >= `AM_TC_LO && O_MEM.addr <= `AM_TC_HI
          && (op_q == `AM_OP_STORE_WORD
              || op_q == `AM_OP_LOAD_WORD)) // RQ13 RQ7
      else $error("timer reference misdecoded");
   a_store_acc_hold: assert property (O_MEM.req && O_MEM.wr
      |-> $stable(O_ACC)) // RQ14
      else $error("accumulator moved during store");

   c_const_load: cover property (start && legal && I_INSTR.use_const);
   c_word_load:  cover property (state_q == acc_move_pkg::ST_READ
                                 && I_MEM.ack);
   c_tc_store:   cover property (O_MEM.req && O_MEM.wr && O_MEM.tc);
   c_unpowered:  cover property (idle && I_EXEC && !I_POWER);

endmodule : accumulator_data_move_unit

/* File: shared/acc_move_regs.svh */
// Purpose: Named constants for the accumulator data move unit
// Assumes: Reference addresses are 9-bit binary forms of octal numbers
// Notes:   Included by bare name; definitions only
`ifndef ACC_MOVE_REGS_SVH
`define ACC_MOVE_REGS_SVH

// ---------------------------------------------------------------
// Operation codes
// ---------------------------------------------------------------
`define AM_OP_LOAD_WORD   8'h50
`define AM_OP_LOAD_BYTE   8'h51
`define AM_OP_LOAD_HI_NIB 8'h52
`define AM_OP_LOAD_LO_NIB 8'h53
`define AM_OP_LOAD_INMOD  8'h55
`define AM_OP_STORE_WORD  8'h60
`define AM_OP_STORE_BYTE  8'h61
`define AM_OP_STORE_HI    8'h62
`define AM_OP_STORE_LO    8'h63

// ---------------------------------------------------------------
// Reference ranges (octal 000..677 as binary)
// ---------------------------------------------------------------
`define AM_IO_LO          9'h000
`define AM_IO_HI_B        9'h00D
`define AM_IO_HI_W        9'h00C
`define AM_IO2_LO         9'h038
`define AM_IO2_HI_B       9'h03E
`define AM_IO2_HI_W       9'h03D
`define AM_REL_LO         9'h00E
`define AM_REL_HI_B       9'h01F
`define AM_REL_HI_W       9'h01E
`define AM_SHR_LO         9'h020
`define AM_SHR_HI_B       9'h02F
`define AM_SHR_HI_W       9'h02E
`define AM_DAT_LO         9'h100
`define AM_DAT_HI_B       9'h17F
`define AM_DAT_HI_W       9'h17E
`define AM_TC_LO          9'h180
`define AM_TC_HI          9'h1BF
`define AM_INMOD_HI       9'h005

// ---------------------------------------------------------------
// Lane enables and fill values
// ---------------------------------------------------------------
`define AM_NIB_ALL        4'hF
`define AM_NIB_BYTE       4'h3
`define AM_NIB_HI         4'h2
`define AM_NIB_LO         4'h1
`define AM_NIB_NONE       4'h0
`define AM_BCD_MAX        4'h9
`define AM_ZERO_BYTE      8'h00
`define AM_ZERO_NIB       4'h0
`define AM_ACC_RESET      16'h0000

`endif

/* File: shared/acc_move_pkg.sv */
// Purpose: Types shared by the accumulator data move unit and its bench
// Assumes: Reference memory answers every request with one ack pulse
// Notes:   Constants live in acc_move_regs.svh
package acc_move_pkg;

   // ------------------------------------------------------------
   // Sequencer states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } state_t;

   // ------------------------------------------------------------
   // Instruction, memory request and memory answer
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  opcode;
      logic [8:0]  ref_addr;
      logic        use_const;
      logic [15:0] konst;
   } instr_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic        tc;
      logic [8:0]  addr;
      logic [15:0] data;
      logic [3:0]  nib_en;
   } mem_req_t;

   typedef struct packed {
      logic        ack;
      logic [15:0] data;
   } mem_rsp_t;

endpackage : acc_move_pkg

/* File: tb/ref_memory_model.sv */
// Purpose: Reference memory and timer word image behind the move unit
// Assumes: One request at a time; request held until our ack is seen
// Notes:   Bench presets and reads the arrays directly by hierarchy
`timescale 1ns/1ps

module ref_memory_model (
   // Clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_rstn,
   // Request side and ack delay
   input  wire acc_move_pkg::mem_req_t i_mem,
   input  wire logic [3:0]             i_wait,
   // Answer side
   output acc_move_pkg::mem_rsp_t      o_mem
);
   logic [7:0]  mem [0:511];  // Byte references
   logic [15:0] tcm [0:63];   // Timer/counter words
   logic [3:0]  cnt_q;
   logic        hold_q;       // Blocks a second ack to the same request
   int          n;

   // Ack i_wait+1 cycles after the request; stale data scrambled, never left standing
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_mem  <= '{ack: 1'b0, data: 16'hA5A5};
         cnt_q  <= 4'h0;
         hold_q <= 1'b0;
      end else begin
         o_mem.ack  <= 1'b0;
         o_mem.data <= ~o_mem.data;
         if (!i_mem.req) begin
            cnt_q  <= 4'h0;
            hold_q <= 1'b0;
         end else if (!hold_q && cnt_q == i_wait) begin
            o_mem.ack <= 1'b1;
            hold_q    <= 1'b1;
            if (!i_mem.wr && i_mem.tc)
               o_mem.data <= tcm[i_mem.addr[5:0]];
            else if (!i_mem.wr)
               o_mem.data <= {mem[i_mem.addr + 1], mem[i_mem.addr]};
            // Only enabled nibbles change
            for (n = 0; n < 4; n++) begin
               if (i_mem.wr && i_mem.nib_en[n] && i_mem.tc)
                  tcm[i_mem.addr[5:0]][4*n+:4] <= i_mem.data[4*n+:4];
               else if (i_mem.wr && i_mem.nib_en[n])
                  mem[i_mem.addr + n/2][4*(n%2)+:4] <= i_mem.data[4*n+:4];
            end
         end else if (!hold_q) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule : ref_memory_model

/* File: tb/accumulator_data_move_unit_test.sv */
// Purpose: Self-checking bench for the accumulator data move unit
// Assumes: Memory model answers with a settable ack delay
// Notes:   Each scenario task drives and judges on its own
`timescale 1ns/1ps
`include "acc_move_regs.svh"

module accumulator_data_move_unit_test;
   logic                   I_CLK = 1'b0;
   logic                   I_RSTN = 1'b0;
   logic                   I_EXEC = 1'b0;
   logic                   I_POWER = 1'b0;
   acc_move_pkg::instr_t   I_INSTR = '0;
   acc_move_pkg::mem_req_t O_MEM;
   acc_move_pkg::mem_rsp_t I_MEM;
   logic [15:0]            O_ACC;
   logic                   O_BUSY, O_DONE, O_REFUSED;
   logic [3:0]             mem_wait = 4'h0;
   logic                   req_seen, ref_seen;
   int                     fail_count = 0;
   int                     compares = 0;

   // 200 MHz clock
   always #2.5 I_CLK = ~I_CLK;

   accumulator_data_move_unit i_accumulator_data_move_unit (
      .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_EXEC(I_EXEC), .I_POWER(I_POWER),
      .I_INSTR(I_INSTR), .O_MEM(O_MEM), .I_MEM(I_MEM), .O_ACC(O_ACC),
      .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_REFUSED(O_REFUSED));

   ref_memory_model i_ref_memory_model (
      .i_clk(I_CLK), .i_rstn(I_RSTN), .i_mem(O_MEM), .i_wait(mem_wait),
      .o_mem(I_MEM));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   task automatic check_word(input string what, input logic [15:0] exp,
                             input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_flag(input string what, input logic exp,
                             input logic got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : check_flag

   function automatic logic [15:0] mw(input int a);
      return {i_ref_memory_model.mem[a+1], i_ref_memory_model.mem[a]};
   endfunction : mw

   task automatic set_word(input int a, input logic [15:0] w);
      i_ref_memory_model.mem[a]   = w[7:0];
      i_ref_memory_model.mem[a+1] = w[15:8];
   endtask : set_word

   // One instruction: strobe for one cycle, then wait for done
   task automatic run(input logic [7:0] op, input logic [8:0] ra,
                      input logic pw, input logic uc, input logic [15:0] k);
      int n;
      req_seen = 1'b0;
      ref_seen = 1'b0;
      @(posedge I_CLK);
      I_EXEC  <= 1'b1;
      I_POWER <= pw;
      I_INSTR <= '{opcode: op, ref_addr: ra, use_const: uc, konst: k};
      @(posedge I_CLK);
      I_EXEC <= 1'b0;
      for (n = 0; n < 60; n++) begin
         #1;
         if (O_MEM.req === 1'b1 || O_BUSY === 1'b1) req_seen = 1'b1;
         if (O_DONE === 1'b1) begin
            ref_seen = O_REFUSED;
            break;
         end
         @(posedge I_CLK);
      end
      if (n == 60) begin
         fail_count++;
         $display("ERROR done expected 1 seen 0");
         final_report();
      end
   endtask : run

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_const();
      run(`AM_OP_LOAD_WORD, 9'h000, 1'b1, 1'b1, 16'h9999);
      check_word("const acc", 16'h9999, O_ACC);
      check_flag("const mem req", 1'b0, req_seen);
      run(`AM_OP_LOAD_WORD, 9'h000, 1'b1, 1'b1, 16'h12A4);
      check_flag("non-bcd refused", 1'b1, ref_seen);
      check_word("non-bcd acc", 16'h9999, O_ACC);
   endtask : t_const

   task automatic t_word_load();
      set_word(9'h102, 16'h1234);
      i_ref_memory_model.tcm[1] = 16'h0567;
      mem_wait <= 4'h6;
      run(`AM_OP_LOAD_WORD, 9'h102, 1'b1, 1'b0, 16'h0000);
      check_word("word load slow", 16'h1234, O_ACC);
      check_flag("word load req", 1'b1, req_seen);
      mem_wait <= 4'h0;
      run(`AM_OP_LOAD_WORD, 9'h181, 1'b1, 1'b0, 16'h0000);
      check_word("timer word load", 16'h0567, O_ACC);
      run(`AM_OP_LOAD_WORD, 9'h17F, 1'b1, 1'b0, 16'h0000);
      check_flag("word at 577 refused", 1'b1, ref_seen);
   endtask : t_word_load

   task automatic t_byte_loads();
      set_word(9'h100, 16'hCDAB);
      i_ref_memory_model.mem[9'h17F] = 8'h5C;
      run(`AM_OP_LOAD_WORD, 9'h000, 1'b1, 1'b1, 16'h9999);
      run(`AM_OP_LOAD_BYTE, 9'h100, 1'b1, 1'b0, 16'h0000);
      check_word("byte load", 16'h00AB, O_ACC);
      run(`AM_OP_LOAD_WORD, 9'h000, 1'b1, 1'b1, 16'h9999);
      run(`AM_OP_LOAD_HI_NIB, 9'h17F, 1'b1, 1'b0, 16'h0000);
      check_word("high nibble load", 16'h9995, O_ACC);
      run(`AM_OP_LOAD_LO_NIB, 9'h17F, 1'b1, 1'b0, 16'h0000);
      check_word("low nibble load", 16'h999C, O_ACC);
      run(`AM_OP_LOAD_BYTE, 9'h180, 1'b1, 1'b0, 16'h0000);
      check_flag("byte op timer refused", 1'b1, ref_seen);
      check_word("refused acc", 16'h999C, O_ACC);
   endtask : t_byte_loads

   task automatic t_inmod();
      set_word(9'h004, 16'h5678);
      run(`AM_OP_LOAD_INMOD, 9'h004, 1'b1, 1'b0, 16'h0000);
      check_word("input module load", 16'h5678, O_ACC);
      run(`AM_OP_LOAD_INMOD, 9'h006, 1'b1, 1'b0, 16'h0000);
      check_flag("input module range", 1'b1, ref_seen);
   endtask : t_inmod

   task automatic t_stores();
      logic [8:0] tgt [5] = '{9'h000, 9'h00E, 9'h020, 9'h104, 9'h038};
      run(`AM_OP_LOAD_WORD, 9'h000, 1'b1, 1'b1, 16'h1234);
      foreach (tgt[i]) begin
         set_word(tgt[i], 16'h0000);
         run(`AM_OP_STORE_WORD, tgt[i], 1'b1, 1'b0, 16'h0000);
         check_word("word store", 16'h1234, mw(tgt[i]));
      end
      run(`AM_OP_STORE_WORD, 9'h1BF, 1'b1, 1'b0, 16'h0000);
      check_word("timer store", 16'h1234, i_ref_memory_model.tcm[63]);
      set_word(9'h110, 16'hA55A);
      run(`AM_OP_STORE_BYTE, 9'h110, 1'b1, 1'b0, 16'h0000);
      check_word("byte store", 16'hA534, mw(9'h110));
      set_word(9'h112, 16'h7777);
      run(`AM_OP_STORE_HI, 9'h112, 1'b1, 1'b0, 16'h0000);
      check_word("high nibble store", 16'h7747, mw(9'h112));
      run(`AM_OP_STORE_LO, 9'h112, 1'b1, 1'b0, 16'h0000);
      check_word("low nibble store", 16'h7744, mw(9'h112));
   endtask : t_stores

   task automatic t_unpowered();
      set_word(9'h120, 16'h2211);
      run(`AM_OP_STORE_WORD, 9'h120, 1'b0, 1'b0, 16'h0000);
      check_flag("unpowered mem req", 1'b0, req_seen);
      check_word("unpowered target", 16'h2211, mw(9'h120));
      run(`AM_OP_LOAD_WORD, 9'h000, 1'b0, 1'b1, 16'h9999);
      check_word("unpowered acc", 16'h1234, O_ACC);
      check_flag("unpowered refused", 1'b0, ref_seen);
   endtask : t_unpowered

   // Reset, then every scenario in turn
   initial begin
      repeat (10) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      #1;
      check_word("reset acc", 16'h0000, O_ACC);
      check_flag("reset busy", 1'b0, O_BUSY);
      check_flag("reset mem req", 1'b0, O_MEM.req);
      check_flag("reset done", 1'b0, O_DONE);
      t_const();
      t_word_load();
      t_byte_loads();
      t_inmod();
      t_stores();
      t_unpowered();
      final_report();
   end
endmodule : accumulator_data_move_unit_test
